/* src/bp_comparator.v */
// One I/O breakpoint comparator with its own enable and field decode
`include "dbg_trap_consts.vh"
module bp_comparator #(
    parameter AW = 64
) (
    input  wire [AW-1:0] bp_addr,
    input  wire          local_en,
    input  wire          global_en,
    input  wire [1:0]    match_type,
    input  wire [1:0]    match_len,
    input  wire          ext_en,
    input  wire          io_valid,
    input  wire [15:0]   io_port,
    input  wire [1:0]    io_size,
    output wire          hit
);
    wire [AW-1:0] port_ext;
    wire          armed;
    wire          is_io;
    wire          len_ok;
    assign port_ext = {{(AW-16){1'b0}}, io_port};
    assign armed    = local_en | global_en;
    // Type 10b only means I/O while extensions enabled
    // Codes 00b, 01b and 11b belong to the address matchers
    assign is_io    = (match_type != `MT_INSTR) &
                      (match_type != `MT_WRITE) &
                      (match_type != `MT_RW) & ext_en;
    // Length code 10b is not a legal I/O size, so never matches
    assign len_ok   = (match_len == io_size) &&
                      (match_len != 2'h2);
    assign hit = armed & is_io & len_ok & io_valid &
                 (port_ext == bp_addr);
endmodule // bp_comparator

/* src/dbg_trap_consts.vh */
// Constants shared by the debug trap and branch record logic
// What this block does
// - Comparator armed by local or global enable
// - Match type 10b matches I/O ports when extensions on
// - I/O length 00b,01b,11b: byte, word, doubleword
// - Port address zero-extended to 64 bits
// - I/O hit traps after instruction, sets hit flag
// - Repeated string I/O traps per iteration, pushes instruction unless last iteration
// - Trapping task switch traps before first instruction
// - Guard bit traps debug register access beforehand
// - Guard trap clears guard, sets access-detect flag
// - Trap flag set by return delays one instruction; pop only clears it
// - Fast system return traps before target executes
// - Step trap clears live flag, pushes set image
// - Step trap beats pending external interrupt
// - Software interrupt instructions clear trap flag
// - Breakpoint instructions vector to breakpoint handler
// - Branch loads last-branch source and target
// - Interrupt loads interrupted and handler offsets
// - Most interrupts copy branch record to interrupt record
// - Debug exception clears record enable, keeps contents
// - Recording covers every listed control-transfer kind
// - Types 00b instruction, 01b write, 11b read-write
`ifndef DBG_TRAP_CONSTS_VH
`define DBG_TRAP_CONSTS_VH
// Debug control register field positions
`define DCR_L0          0
`define DCR_G0          1
`define DCR_GUARD       13
`define DCR_TYPE0       16
`define DCR_LEN0        18
`define DCR_RESET       64'h0000000000000400
// Debug status register field positions
`define DSR_ACCESS      13
`define DSR_STEP        14
`define DSR_TASK        15
`define DSR_RESET       64'h00000000FFFF0FF0
// Match type and length encodings
`define MT_INSTR        2'h0
`define MT_WRITE        2'h1
`define MT_IO           2'h2
`define MT_RW           2'h3
`define ML_BYTE         2'h0
`define ML_WORD         2'h1
`define ML_DWORD        2'h3
// Exception vectors
`define VEC_DEBUG       8'h01
`define VEC_BREAKPOINT  8'h03
// Control transfer kinds
`define XF_NONE         4'h0
`define XF_BRANCH       4'h1
`define XF_SOFT_INT     4'h2
`define XF_ONE_BYTE     4'h3
`define XF_OVERFLOW     4'h4
`define XF_ICE          4'h5
`define XF_EXCEPTION    4'h6
`define XF_MCHECK       4'h7
`define XF_EXT_INT      4'h8
`define XF_NMI          4'h9
`define XF_SMI          4'hA
`define XF_RESUME       4'hB
`define XF_SYSCALL      4'hC
`define XF_FAST_SYSTEM_RETURN       4'hD
`define XF_INTERRUPT_RETURN         4'hE
`endif

/* src/debug_trap_and_branch_record.v */
// Debug exception, single step and branch recording logic of the core
`include "dbg_trap_consts.vh"
module debug_trap_and_branch_record #(
    parameter NCMP = 4,
    parameter AW   = 64
) (
    input  wire            mclk,
    input  wire            sys_rst,
    // Software writes of the debug state
    input  wire            dcr_wr,
    input  wire [63:0]     dcr_wdata,
    input  wire            dsr_wr,
    input  wire [63:0]     dsr_wdata,
    input  wire            bpa_wr,
    input  wire [1:0]      bpa_idx,
    input  wire [AW-1:0]   bpa_wdata,
    input  wire            msr_wr,
    input  wire            msr_wdata,
    input  wire            debug_extensions_enable,
    // Pipeline events
    input  wire            retire,
    input  wire            io_valid,
    input  wire [15:0]     io_port,
    input  wire [1:0]      io_size,
    input  wire            io_rep_string,
    input  wire            io_rep_more,
    input  wire            task_switch,
    input  wire            task_trap_bit,
    input  wire            dbg_reg_access,
    input  wire            tf_set_by_return,
    input  wire            tf_set_by_fast_system_return,
    input  wire            tf_clear_by_pop,
    input  wire            ext_int_pending,
    input  wire [3:0]      xfer_kind,
    input  wire [AW-1:0]   xfer_from,
    input  wire [AW-1:0]   xfer_to,
    input  wire [7:0]      soft_int_vector,
    // Results
    output reg  [63:0]     debug_control_reg,
    output reg  [63:0]     debug_status_reg,
    output reg  [AW*4-1:0] breakpoint_address_reg,
    output reg             branch_record_enable,
    output reg  [AW-1:0]   last_branch_source,
    output reg  [AW-1:0]   last_branch_target,
    output reg  [AW-1:0]   last_int_source,
    output reg  [AW-1:0]   last_int_target,
    output reg             trap_flag,
    output reg             pushed_trap_flag,
    output reg             debug_exception,
    output reg             dbg_before_instr,
    output reg             push_instr_addr,
    output reg             breakpoint_exception,
    output reg  [7:0]      exc_vector,
    output reg             service_ext_int,
    output wire            dbg_write_blocked
);
    // Step state machine
    localparam ST_OFF   = 3'b001;
    localparam ST_DELAY = 3'b010;
    localparam ST_ARMED = 3'b100;

    reg  [2:0]      step_reg;
    reg  [2:0]      step_next;
    reg             int_after_reg;
    wire [NCMP-1:0] cmp_hit;
    wire            io_trap;
    wire            task_trap;
    wire            guard_trap;
    wire            step_trap;
    wire            any_dbg;
    wire            is_int;
    wire            is_soft_clear;
    wire            is_bp_vec;
    wire            rec_xfer;

    // One comparator per breakpoint address register
    genvar i;
    generate
        for (i = 0; i < NCMP; i = i + 1) begin : g_cmp
            bp_comparator #(.AW(AW)) u_cmp (
                .bp_addr    (breakpoint_address_reg[i*AW +: AW]),
                .local_en   (debug_control_reg[`DCR_L0 + 2*i]),
                .global_en  (debug_control_reg[`DCR_G0 + 2*i]),
                .match_type (debug_control_reg[`DCR_TYPE0 + 4*i +: 2]),
                .match_len  (debug_control_reg[`DCR_LEN0 + 4*i +: 2]),
                .ext_en     (debug_extensions_enable),
                .io_valid   (io_valid & retire),
                .io_port    (io_port),
                .io_size    (io_size),
                .hit        (cmp_hit[i])
            );
        end
    endgenerate

    // Trap causes; guard trap is taken before the access executes
    assign io_trap    = |cmp_hit;
    assign task_trap  = task_switch & task_trap_bit;
    assign guard_trap = dbg_reg_access &
                        debug_control_reg[`DCR_GUARD];
    assign step_trap  = (retire & step_reg == ST_ARMED) |
                        tf_set_by_fast_system_return;
    assign any_dbg    = io_trap | task_trap | guard_trap | step_trap;
    // Guarded access must not alter any debug register
    assign dbg_write_blocked = guard_trap;

    // Transfer classes for record and trap flag handling
    assign is_soft_clear = retire & ((xfer_kind == `XF_SOFT_INT) |
                           (xfer_kind == `XF_ONE_BYTE) |
                           (xfer_kind == `XF_OVERFLOW));
    assign is_bp_vec = (xfer_kind == `XF_ONE_BYTE) |
                       ((xfer_kind == `XF_SOFT_INT) &
                        (soft_int_vector == `VEC_BREAKPOINT));
    assign is_int = (xfer_kind == `XF_SOFT_INT) |
                    (xfer_kind == `XF_ONE_BYTE) |
                    (xfer_kind == `XF_OVERFLOW) |
                    (xfer_kind == `XF_ICE) |
                    (xfer_kind == `XF_EXCEPTION) |
                    (xfer_kind == `XF_MCHECK) |
                    (xfer_kind == `XF_EXT_INT) |
                    (xfer_kind == `XF_NMI) |
                    (xfer_kind == `XF_SMI);
    // Every kind from branch through interrupt return is recorded
    assign rec_xfer = (xfer_kind != `XF_NONE);

    // Step sequencing: a newly set flag waits one instruction
    always @* begin
        step_next = step_reg;
        case (step_reg)
            ST_OFF: begin
                if (tf_set_by_return)
                    step_next = ST_DELAY;
            end
            ST_DELAY: begin
                if (retire)
                    step_next = ST_ARMED;
            end
            ST_ARMED: begin
                if (retire)
                    step_next = ST_OFF;
            end
            default: step_next = ST_OFF;
        endcase
        if (tf_clear_by_pop | is_soft_clear)
            step_next = ST_OFF;
        if (any_dbg)
            step_next = ST_OFF;
    end

    // Step state and trap flag
    always @(posedge mclk) begin
        if (sys_rst) begin
            step_reg  <= ST_OFF;
            trap_flag <= 1'b0;
        end else begin
            step_reg <= step_next;
            if (any_dbg | is_soft_clear | tf_clear_by_pop)
                trap_flag <= 1'b0;
            else if (tf_set_by_return | tf_set_by_fast_system_return)
                trap_flag <= 1'b1;
        end
    end

    // Exception outputs from flip-flops; exc_vector holds, pushed_trap_flag follows trap_flag but is set on a step trap, the rest pulse
    always @(posedge mclk) begin
        if (sys_rst) begin
            debug_exception      <= 1'b0;
            dbg_before_instr     <= 1'b0;
            push_instr_addr      <= 1'b0;
            breakpoint_exception <= 1'b0;
            exc_vector           <= 8'h00;
            pushed_trap_flag     <= 1'b0;
            service_ext_int      <= 1'b0;
            int_after_reg        <= 1'b0;
        end else begin
            debug_exception      <= any_dbg;
            // Before-instruction: guard, task entry, fast_system_return step
            dbg_before_instr     <= guard_trap | task_trap |
                                    tf_set_by_fast_system_return;
            // Unfinished repeat loop restarts at the instruction
            push_instr_addr      <= io_trap & io_rep_string &
                                    io_rep_more;
            breakpoint_exception <= ~any_dbg & retire & is_bp_vec;
            if (any_dbg)
                exc_vector <= `VEC_DEBUG;
            else if (retire & is_bp_vec)
                exc_vector <= `VEC_BREAKPOINT;
            // Stack image keeps the flag that was live at the trap
            pushed_trap_flag <= step_trap ? 1'b1 : trap_flag;
            // Interrupt is taken right after handler entry
            int_after_reg   <= step_trap & ext_int_pending;
            service_ext_int <= int_after_reg;
        end
    end

    // Debug control register; guard cleared on its own trap
    always @(posedge mclk) begin
        if (sys_rst) begin
            debug_control_reg <= `DCR_RESET;
        end else if (guard_trap) begin
            debug_control_reg[`DCR_GUARD] <= 1'b0;
        end else if (dcr_wr) begin
            debug_control_reg <= dcr_wdata;
        end
    end

    // Status flags: hardware set wins over software write
    always @(posedge mclk) begin
        if (sys_rst) begin
            debug_status_reg <= `DSR_RESET;
        end else begin
            if (dsr_wr & ~guard_trap)
                debug_status_reg <= dsr_wdata |
                    {48'h0, {12{1'b0}}, cmp_hit} |
                    ({63'h0, task_trap} << `DSR_TASK) |
                    ({63'h0, step_trap} << `DSR_STEP);
            else begin
                debug_status_reg[NCMP-1:0] <=
                    debug_status_reg[NCMP-1:0] | cmp_hit;
                if (task_trap)
                    debug_status_reg[`DSR_TASK] <= 1'b1;
                if (step_trap)
                    debug_status_reg[`DSR_STEP] <= 1'b1;
                if (guard_trap)
                    debug_status_reg[`DSR_ACCESS] <= 1'b1;
            end
        end
    end

    // Breakpoint address registers, blocked while guarded
    always @(posedge mclk) begin
        if (sys_rst)
            breakpoint_address_reg <= {(AW*4){1'b0}};
        else if (bpa_wr & ~guard_trap)
            breakpoint_address_reg[bpa_idx*AW +: AW] <= bpa_wdata;
    end

    // Record enable; the task trap bit lives outside, untouched
    always @(posedge mclk) begin
        if (sys_rst)
            branch_record_enable <= 1'b0;
        else if (any_dbg)
            branch_record_enable <= 1'b0;
        else if (msr_wr)
            branch_record_enable <= msr_wdata;
    end

    // Branch and interrupt records; contents kept on debug trap
    always @(posedge mclk) begin
        if (sys_rst) begin
            last_branch_source <= {AW{1'b0}};
            last_branch_target <= {AW{1'b0}};
            last_int_source    <= {AW{1'b0}};
            last_int_target    <= {AW{1'b0}};
        end else if (branch_record_enable & retire & rec_xfer &
                     ~any_dbg) begin
            last_branch_source <= xfer_from;
            last_branch_target <= xfer_to;
            // Copy previous branch record except excluded kinds
            if (is_int & (xfer_kind != `XF_MCHECK) &
                (xfer_kind != `XF_ICE)) begin
                last_int_source <= last_branch_source;
                last_int_target <= last_branch_target;
            end
        end
    end
endmodule // debug_trap_and_branch_record

/* verification/debug_trap_and_branch_record_sva.sv */
// Port assertions for the debug trap and branch record block
`include "dbg_trap_consts.vh"
module debug_trap_and_branch_record_sva #(
    parameter AW = 64
) (
    input wire          mclk,
    input wire          sys_rst,
    input wire          msr_wr,
    input wire          retire,
    input wire          task_switch,
    input wire          task_trap_bit,
    input wire          dbg_reg_access,
    input wire          tf_set_by_return,
    input wire          tf_set_by_fast_system_return,
    input wire          ext_int_pending,
    input wire [3:0]    xfer_kind,
    input wire [AW-1:0] xfer_from,
    input wire [63:0]   debug_control_reg,
    input wire [63:0]   debug_status_reg,
    input wire          branch_record_enable,
    input wire [AW-1:0] last_branch_source,
    input wire [AW-1:0] last_int_source,
    input wire          trap_flag,
    input wire          pushed_trap_flag,
    input wire          debug_exception,
    input wire          dbg_before_instr,
    input wire          breakpoint_exception,
    input wire [7:0]    exc_vector,
    input wire          service_ext_int,
    input wire          dbg_write_blocked
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire guard_trap = dbg_reg_access && debug_control_reg[13];
    // Guarded access traps before the move and frees the guard
    a_guard_trap: assert property (guard_trap |=> debug_exception && dbg_before_instr) else $error("guard trap missing");
    a_guard_block: assert property (guard_trap |-> dbg_write_blocked) else $error("guarded write not blocked");
    a_guard_clear: assert property (guard_trap |=> !debug_control_reg[13] && debug_status_reg[13]) else $error("guard not released");
    a_task_trap: assert property (task_switch && task_trap_bit |=> debug_exception && dbg_before_instr && debug_status_reg[15]) else $error("task trap missing");
    a_fast_system_return_now: assert property (tf_set_by_fast_system_return |=> debug_exception && debug_status_reg[14]) else $error("fast return trap late");
    a_step_flags: assert property (debug_exception && $rose(debug_status_reg[14]) |-> !trap_flag && pushed_trap_flag) else $error("step flag images wrong");
    a_step_first: assert property (debug_exception && $rose(debug_status_reg[14]) && ext_int_pending |=> service_ext_int) else $error("interrupt not after step");
    a_tf_clear: assert property (retire && xfer_kind inside {`XF_SOFT_INT, `XF_ONE_BYTE, `XF_OVERFLOW} && !tf_set_by_return && !tf_set_by_fast_system_return |=> !trap_flag) else $error("trap flag kept");
    a_bp_vector: assert property (retire && xfer_kind == `XF_ONE_BYTE |=> breakpoint_exception && exc_vector == `VEC_BREAKPOINT) else $error("one byte trap vector");
    a_rec_source: assert property (retire && xfer_kind inside {`XF_BRANCH, `XF_EXT_INT} && branch_record_enable && !trap_flag && !task_switch && !dbg_reg_access |=> last_branch_source == $past(xfer_from)) else $error("record source");
    a_mcheck_keep: assert property (retire && xfer_kind inside {`XF_MCHECK, `XF_ICE} |=> $stable(last_int_source)) else $error("interrupt record moved");
    a_dbg_stop_rec: assert property (debug_exception && !$past(msr_wr) |-> !branch_record_enable && $stable(last_branch_source)) else $error("record not frozen");
    c_guard: cover property (guard_trap ##1 debug_exception);
    c_step_int: cover property (debug_exception && $rose(debug_status_reg[14]) ##1 service_ext_int);
    c_bp: cover property (breakpoint_exception);
endmodule // debug_trap_and_branch_record_sva

bind debug_trap_and_branch_record debug_trap_and_branch_record_sva #(.AW(AW)) sva (.*);

/* verification/debug_trap_and_branch_record_tb_top.sv */
// Self-checking bench for the debug trap and branch record block
`include "dbg_trap_consts.vh"
module debug_trap_and_branch_record_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, sys_rst, dcr_wr, dsr_wr, bpa_wr;
    logic msr_wr, msr_wdata, debug_extensions_enable;
    logic tf_clear_by_pop, ext_int_pending;
    logic [63:0] dcr_wdata, dsr_wdata, bpa_wdata;
    logic [1:0]  bpa_idx, io_size;
    logic retire, io_valid, io_rep_string, io_rep_more, task_switch;
    logic task_trap_bit, dbg_reg_access, tf_set_by_return, tf_set_by_fast_system_return;
    logic [15:0] io_port;
    logic [3:0]  xfer_kind;
    logic [7:0]  soft_int_vector, exc_vector;
    logic [63:0] xfer_from, xfer_to, debug_control_reg, debug_status_reg;
    logic [63:0] last_branch_source, last_branch_target;
    logic [63:0] last_int_source, last_int_target;
    logic [255:0] breakpoint_address_reg;
    logic branch_record_enable, trap_flag, pushed_trap_flag, debug_exception;
    logic dbg_before_instr, push_instr_addr, breakpoint_exception;
    logic service_ext_int, dbg_write_blocked;
    logic [1:0] lens [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
    int err_count = 0, comparisons = 0;
    debug_trap_and_branch_record #(.NCMP(4), .AW(64)) dut (.*);
    pipe_model pm (.*);
    always #20 mclk = ~mclk;
    task automatic chk(input logic [63:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Software write: 0 control, 1 status, 2 address slot i, 3 recording
    task automatic sw(input int w, input logic [63:0] d,
                      input logic [1:0] i = 2'h0);
        @(posedge mclk);
        {dcr_wr, dsr_wr, bpa_wr, msr_wr} <= {w == 0, w == 1, w == 2, w == 3};
        {dcr_wdata, dsr_wdata, bpa_wdata, bpa_idx} <= {d, d, d, i};
        msr_wdata <= d[0];
        @(posedge mclk);
        {dcr_wr, dsr_wr, bpa_wr, msr_wr} <= 4'h0;
        #1;
    endtask
    // Extensions switch, changed on a rising edge
    task automatic ext(input logic v);
        @(posedge mclk);
        debug_extensions_enable <= v;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        err_count++;
        test_done();
    end
    initial begin
        sys_rst <= 1'b1;
        {dcr_wr, dsr_wr, bpa_wr, msr_wr, msr_wdata} <= 5'h00;
        {debug_extensions_enable, tf_clear_by_pop, ext_int_pending} <= 3'h0;
        {dcr_wdata, dsr_wdata, bpa_wdata, bpa_idx} <= '0;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk(debug_control_reg, 64'h0000000000000400);
        chk(debug_status_reg, 64'h00000000FFFF0FF0);
        // One comparator armed at a time, last one by its global enable
        for (int i = 0; i < 4; i++) begin
            sw(2, 64'h0000010000000080 + i, i);
            sw(0, (64'h1 << (2 * i + i / 3)) | (64'h2 << (16 + 4 * i))
                | (64'(lens[i]) << (18 + 4 * i)));
            sw(1, 64'h0);
            ext(1'b1);
            pm.io(16'h0080 + i, lens[i], 0, 0);
            chk(debug_exception, 0);
            sw(2, 64'h80 + i, i);
            ext(1'b0);
            pm.io(16'h0080 + i, lens[i], 0, 0);
            chk(debug_exception, 0);
            ext(1'b1);
            pm.io(16'h0080 + i, lens[i] ^ 2'h1, 0, 0);
            chk(debug_exception, 0);
            pm.io(16'h0080 + i, lens[i], 0, 0);
            chk(debug_exception, 1);
            chk(debug_status_reg[3:0], 4'h1 << i);
        end
        pm.io(16'h0083, 2'h3, 1, 1);
        chk({debug_exception, push_instr_addr}, 2'h3);
        pm.io(16'h0083, 2'h3, 1, 0);
        chk({debug_exception, push_instr_addr}, 2'h2);
        // Non-port match types never see port instructions
        for (int t = 0; t < 4; t++) begin
            if (t != 2) begin
                sw(0, 64'h00000000C0000080 | (64'(t) << 28));
                pm.io(16'h0083, 2'h3, 0, 0);
                chk(debug_exception, 0);
            end
        end
        // Guarded move with a racing address write
        sw(0, 64'h2000);
        fork
            pm.flag(3);
            sw(2, 64'hDEAD, 2'h0);
        join
        chk({debug_exception, dbg_before_instr}, 2'h3);
        chk(breakpoint_address_reg[63:0], 64'h80);
        chk({debug_control_reg[13], debug_status_reg[13]}, 2'h1);
        pm.flag(2);
        chk({debug_exception, debug_status_reg[15]}, 2'h3);
        // Step with an interrupt waiting
        ext_int_pending <= 1'b1;
        pm.flag(0);
        chk(trap_flag, 1);
        pm.xf(0, `XF_NONE, 0, 0, 0);
        chk(debug_exception, 0);
        pm.xf(2, `XF_NONE, 0, 0, 0);
        chk({debug_exception, debug_status_reg[14]}, 2'h3);
        chk({trap_flag, pushed_trap_flag}, 2'h1);
        @(posedge mclk);
        ext_int_pending <= 1'b0;
        #1;
        chk(service_ext_int, 1);
        sw(1, 64'h0);
        pm.flag(1);
        chk({debug_exception, debug_status_reg[14]}, 2'h3);
        // Pop clearing the flag cancels a pending step
        pm.flag(0);
        @(posedge mclk);
        tf_clear_by_pop <= 1'b1;
        @(posedge mclk);
        tf_clear_by_pop <= 1'b0;
        #1;
        chk(trap_flag, 0);
        repeat (2) pm.xf(0, `XF_NONE, 0, 0, 0);
        chk(debug_exception, 0);
        for (int k = 2; k < 5; k++) begin
            pm.flag(0);
            pm.xf(0, 4'(k), 0, 0, 8'h21);
            chk(trap_flag, 0);
        end
        for (int j = 0; j < 3; j++) begin
            pm.xf(0, j ? `XF_SOFT_INT : `XF_ONE_BYTE, 0, 0, j == 2 ? 8'h21 : 8'h03);
            chk(breakpoint_exception, j < 2);
            if (j < 2) chk(exc_vector, `VEC_BREAKPOINT);
        end
        // Recording across every transfer kind
        sw(3, 64'h1);
        for (int k = 1; k < 15; k++) begin
            pm.xf(0, 4'(k), 64'h1000 + k, 64'h2000 + k, 8'h21);
            chk(last_branch_source, 64'h1000 + k);
            chk(last_branch_target, 64'h2000 + k);
        end
        repeat (2) pm.xf(0, `XF_EXT_INT, 64'hA0, 64'hB0, 0);
        chk(last_int_source, 64'hA0);
        chk(last_int_target, 64'hB0);
        for (int j = 0; j < 2; j++) begin
            pm.xf(0, j ? `XF_ICE : `XF_MCHECK, 64'hC0, 64'hD0, 0);
            chk(last_int_source, 64'hA0);
            chk(last_branch_source, 64'hC0);
        end
        pm.flag(1);
        chk(branch_record_enable, 0);
        chk(last_branch_source, 64'hC0);
        pm.xf(0, `XF_BRANCH, 64'hE0, 64'hF0, 0);
        chk(last_branch_source, 64'hC0);
        test_done();
    end
endmodule // debug_trap_and_branch_record_tb_top

/* verification/pipe_model.sv */
// Pipeline event source facing the debug trap block
module pipe_model (
    input  wire         mclk,
    output logic        retire, io_valid, io_rep_string, io_rep_more,
    output logic        task_switch, task_trap_bit, dbg_reg_access,
    output logic        tf_set_by_return, tf_set_by_fast_system_return,
    output logic [15:0] io_port,
    output logic [1:0]  io_size,
    output logic [3:0]  xfer_kind,
    output logic [63:0] xfer_from, xfer_to,
    output logic [7:0]  soft_int_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {retire, io_valid, io_rep_string, io_rep_more, task_switch,
        task_trap_bit, dbg_reg_access, tf_set_by_return, tf_set_by_fast_system_return,
        io_port, io_size, xfer_kind, xfer_from, xfer_to, soft_int_vector} = '0;
    // End of event: strobes drop, stale data is scrambled on purpose
    task automatic fin;
        @(posedge mclk);
        {retire, io_valid, task_switch, dbg_reg_access} <= 4'h0;
        {tf_set_by_return, tf_set_by_fast_system_return} <= 2'h0;
        xfer_kind <= 4'h0;
        xfer_from <= ~xfer_from;
        io_port <= ~io_port;
        #1;
    endtask
    // Retiring control transfer; gap idles the pipe for a slow answer
    task automatic xf(input int gap, input logic [3:0] k,
                      input logic [63:0] f, t, input logic [7:0] v);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        {retire, xfer_kind, xfer_from, xfer_to} <= {1'b1, k, f, t};
        soft_int_vector <= v;
        fin();
    endtask
    // Retiring port instruction, optionally a repeated string one
    task automatic io(input logic [15:0] p, input logic [1:0] s,
                      input logic rep, more);
        @(posedge mclk);
        {retire, io_valid, io_port, io_size} <= {2'h3, p, s};
        {io_rep_string, io_rep_more} <= {rep, more};
        fin();
    endtask
    // 0 return sets flag, 1 fast return, 2 trapping task, 3 guarded move
    task automatic flag(input int w);
        @(posedge mclk);
        tf_set_by_return <= (w == 0);
        tf_set_by_fast_system_return <= (w == 1);
        task_switch <= (w == 2);
        task_trap_bit <= (w == 2);
        dbg_reg_access <= (w == 3);
        fin();
    endtask
endmodule // pipe_model
